// ### rtl/psc_defs.svh
// Purpose: Constants of the pump staging controller.
// Assumes: Included by the package and the design modules.
// Notes: Speeds and thresholds are in 0.1 Hz steps.
`ifndef PSC_DEFS_SVH
`define PSC_DEFS_SVH

// Timing
`define PSC_CLK_NS 20
`define PSC_TICK_NS 1000000000
`define PSC_SEC_PER_HOUR 3600

// Pump slots
`define PSC_NPUMP 4

// Register offsets (word index on the register port)
`define PSC_OFS_FUNC 4'h0
`define PSC_OFS_COUNT 4'h1
`define PSC_OFS_CHG 4'h2
`define PSC_OFS_START 4'h3
`define PSC_OFS_STOP 4'h4
`define PSC_OFS_SETTLE 4'h5
`define PSC_OFS_CLR 4'h6
`define PSC_OFS_STATUS 4'h7
`define PSC_OFS_RT0 4'h8
`define PSC_RT_MASK 4'hC

// Reset values
`define PSC_RST_FUNC 3'h0
`define PSC_RST_COUNT 3'h1
`define PSC_RST_CHG 16'h0000
`define PSC_RST_START 16'h01EA
`define PSC_RST_STOP 16'h012C
`define PSC_RST_SETTLE 16'h003C
`define PSC_RST_CLR 1'h0

// Legal ranges
`define PSC_FUNC_MAX 3'h5
`define PSC_COUNT_MIN 3'h1
`define PSC_COUNT_MAX 3'h4
`define PSC_SETTLE_MIN 16'h0002
`define PSC_SETTLE_MAX 16'h0258

`endif

// ### rtl/psc_pkg.sv
// Purpose: Types of the pump staging controller.
// Assumes: Constants come from psc_defs.svh.
// Notes: All state of each module is one packed struct.
`default_nettype none
`include "psc_defs.svh"

package psc_pkg;

    typedef enum logic [0:0]
    {
        PSC_READY = 1'b0,
        PSC_SETTLE = 1'b1
    } psc_phase_type;

    typedef struct packed
    {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } psc_req_type;

    typedef struct packed
    {
        logic [2:0] func;
        logic [2:0] count;
        logic [15:0] chg;
        logic [15:0] start;
        logic [15:0] stop;
        logic [15:0] settle_s;
        logic clr;
    } psc_cfg_type;

    typedef struct packed
    {
        psc_phase_type phase;
        logic [15:0] settle;
        logic [31:0] presc;
        logic tick;
        logic [`PSC_NPUMP-1:0] pump_on;
        psc_cfg_type cfg;
        logic [15:0] rdata;
    } psc_state_type;

    typedef struct packed
    {
        logic [11:0] sec;
        logic [15:0] hours;
    } psc_rc_type;

endpackage
`default_nettype wire

// ### rtl/psc_runclock.sv
// Purpose: Run-time clock of one staging pump, in whole hours.
// Assumes: sec_tick is a one-cycle pulse once a second.
// Notes: Hours saturate rather than wrap.
`timescale 1ns/1ns
`default_nettype none
`include "psc_defs.svh"

module psc_runclock
    import psc_pkg::*;
#(
    parameter int SEC_PER_HOUR = `PSC_SEC_PER_HOUR
)
(
    input wire logic sys_clk, // System clock
    input wire logic reset_n, // Async reset, active low
    input wire logic sec_tick, // One pulse a second
    input wire logic running, // Pump is switched on
    input wire logic clear, // Clear the clock
    output logic [15:0] hours // Accumulated hours
);

    psc_rc_type r;
    psc_rc_type next_r;

    // Count seconds while running, carry into hours
    always_comb
    begin
        next_r = r;
        if (clear)
        begin
            next_r.sec = 12'h000;
            next_r.hours = 16'h0000;
        end
        else if (running && sec_tick)
        begin
            if (r.sec == 12'(SEC_PER_HOUR - 1))
            begin
                next_r.sec = 12'h000;
                // Saturate so a stale pump never looks fresh
                if (r.hours != 16'hFFFF)
                    next_r.hours = r.hours + 16'h0001;
            end
            else
                next_r.sec = r.sec + 12'h001;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            r <= '0;
        else
            r <= next_r;
    end

    assign hours = r.hours;

endmodule // psc_runclock
`default_nettype wire

// ### rtl/psc_staging.sv
// Purpose: Pump staging supervisor of a variable speed drive.
// Assumes: drive_speed is synchronous to sys_clk, in 0.1 Hz steps.
// Notes: One switch-on, switch-off or swap at most per settle period.
//
// What this block does
// RL1: Staging runs only while the function select is nonzero.
// RL2: Staging is limited to the configured pump count, one to four.
// RL3: Nonzero changeover hours rotates pumps to bound run-time spread.
// RL4: Speed above start threshold switches on the next pump.
// RL5: Switch-on picks the available pump with lowest run time.
// RL6: Speed below stop threshold switches off one running pump.
// RL7: Switch-off picks the running pump with highest run time.
// RL8: After a switch-on, switch-off or swap, none of these again until settle time elapsed.
// RL9: Per-pump run-time counters are kept and readable.
// RL10: Writing one to the clock clear clears all run-time counters.
// RL11: Start threshold is never below the stop threshold.
`timescale 1ns/1ns
`default_nettype none
`include "psc_defs.svh"

module psc_staging
    import psc_pkg::*;
#(
    parameter int TICK_CYCLES = `PSC_TICK_NS / `PSC_CLK_NS,
    parameter int SEC_PER_HOUR = `PSC_SEC_PER_HOUR
)
(
    input wire logic sys_clk, // System clock, 50 MHz
    input wire logic reset_n, // Async reset, active low
    input wire psc_req_type reg_req, // Register request
    input wire logic [15:0] drive_speed, // Drive output speed
    output logic [15:0] reg_rdata, // Read data, one cycle later
    output logic [`PSC_NPUMP-1:0] pump_on // Staging pump run outputs
);

    psc_state_type s;
    psc_state_type next_s;
    logic [15:0] hrs [`PSC_NPUMP];
    logic [`PSC_NPUMP-1:0] avail;
    logic enabled;
    logic have_off;
    logic have_on;
    logic [1:0] min_idx;
    logic [1:0] max_idx;
    logic [15:0] min_h;
    logic [15:0] max_h;
    logic want_on;
    logic want_off;
    logic imbalance;
    logic [`PSC_NPUMP-1:0] min_ok;
    logic [`PSC_NPUMP-1:0] max_ok;

    assign enabled = s.cfg.func != 3'h0; // RL1

    // Per-pump slot mask and run-time clock
    genvar g;
    generate
        for (g = 0; g < `PSC_NPUMP; g++)
        begin : g_pump
            assign avail[g] = enabled && (g < int'(s.cfg.count)); // RL2
            // Candidate checks: picked slot against every other slot
            assign min_ok[g] = !avail[g] || s.pump_on[g]
                || (hrs[min_idx] <= hrs[g]); // RL5
            assign max_ok[g] = !s.pump_on[g]
                || (hrs[max_idx] >= hrs[g]); // RL7
            psc_runclock #(
                .SEC_PER_HOUR(SEC_PER_HOUR)
            ) u_clock (
                .sys_clk(sys_clk),
                .reset_n(reset_n),
                .sec_tick(s.tick),
                .running(s.pump_on[g]),
                .clear(s.cfg.clr), // RL10
                .hours(hrs[g]) // RL9
            );
        end
    endgenerate

    // Pick lowest idle and highest running pump; ties go to low index
    always_comb
    begin
        have_off = 1'b0;
        have_on = 1'b0;
        min_idx = 2'h0;
        max_idx = 2'h0;
        min_h = 16'hFFFF;
        max_h = 16'h0000;
        for (int i = 0; i < `PSC_NPUMP; i++)
        begin
            if (avail[i] && !s.pump_on[i] && (!have_off || hrs[i] < min_h))
            begin
                have_off = 1'b1; // RL5
                min_idx = 2'(i);
                min_h = hrs[i];
            end
            if (s.pump_on[i] && (!have_on || hrs[i] > max_h))
            begin
                have_on = 1'b1; // RL7
                max_idx = 2'(i);
                max_h = hrs[i];
            end
        end
    end

    // Threshold and duty comparisons
    assign want_on = drive_speed > s.cfg.start; // RL4
    assign want_off = drive_speed < s.cfg.stop; // RL6
    // Running must lead idle, else the difference wraps and pumps bounce
    assign imbalance = (s.cfg.chg != 16'h0000) && have_on && have_off
        && (max_h > min_h) && ((max_h - min_h) >= s.cfg.chg); // RL3

    // Next state: timebase, registers, staging sequencer
    always_comb
    begin
        next_s = s;
        next_s.tick = 1'b0;
        next_s.rdata = 16'h0000;

        // One-second timebase
        if (s.presc == 32'(TICK_CYCLES - 1))
        begin
            next_s.presc = 32'h0000_0000;
            next_s.tick = 1'b1;
        end
        else
            next_s.presc = s.presc + 32'h0000_0001;

        // Register writes, clamped to legal ranges
        if (reg_req.wr)
        begin
            if (reg_req.addr == `PSC_OFS_FUNC)
            begin
                if (reg_req.wdata > 16'(`PSC_FUNC_MAX))
                    next_s.cfg.func = `PSC_FUNC_MAX;
                else
                    next_s.cfg.func = reg_req.wdata[2:0];
            end
            else if (reg_req.addr == `PSC_OFS_COUNT)
            begin
                if (reg_req.wdata > 16'(`PSC_COUNT_MAX))
                    next_s.cfg.count = `PSC_COUNT_MAX; // RL2
                else if (reg_req.wdata < 16'(`PSC_COUNT_MIN))
                    next_s.cfg.count = `PSC_COUNT_MIN; // RL2
                else
                    next_s.cfg.count = reg_req.wdata[2:0];
            end
            else if (reg_req.addr == `PSC_OFS_CHG)
                next_s.cfg.chg = reg_req.wdata;
            else if (reg_req.addr == `PSC_OFS_START)
            begin
                // Lowering start below stop would kill the hysteresis band
                if (reg_req.wdata < s.cfg.stop)
                    next_s.cfg.start = s.cfg.stop; // RL11
                else
                    next_s.cfg.start = reg_req.wdata;
            end
            else if (reg_req.addr == `PSC_OFS_STOP)
            begin
                if (reg_req.wdata > s.cfg.start)
                    next_s.cfg.stop = s.cfg.start; // RL11
                else
                    next_s.cfg.stop = reg_req.wdata;
            end
            else if (reg_req.addr == `PSC_OFS_SETTLE)
            begin
                if (reg_req.wdata > `PSC_SETTLE_MAX)
                    next_s.cfg.settle_s = `PSC_SETTLE_MAX; // RL8
                else if (reg_req.wdata < `PSC_SETTLE_MIN)
                    next_s.cfg.settle_s = `PSC_SETTLE_MIN; // RL8
                else
                    next_s.cfg.settle_s = reg_req.wdata;
            end
            else if (reg_req.addr == `PSC_OFS_CLR)
                next_s.cfg.clr = reg_req.wdata[0]; // RL10
        end

        // Register reads; unmapped offsets read zero
        if (reg_req.rd)
        begin
            if (reg_req.addr == `PSC_OFS_FUNC)
                next_s.rdata = {13'h0000, s.cfg.func};
            else if (reg_req.addr == `PSC_OFS_COUNT)
                next_s.rdata = {13'h0000, s.cfg.count};
            else if (reg_req.addr == `PSC_OFS_CHG)
                next_s.rdata = s.cfg.chg;
            else if (reg_req.addr == `PSC_OFS_START)
                next_s.rdata = s.cfg.start;
            else if (reg_req.addr == `PSC_OFS_STOP)
                next_s.rdata = s.cfg.stop;
            else if (reg_req.addr == `PSC_OFS_SETTLE)
                next_s.rdata = s.cfg.settle_s;
            else if (reg_req.addr == `PSC_OFS_CLR)
                next_s.rdata = {15'h0000, s.cfg.clr};
            else if (reg_req.addr == `PSC_OFS_STATUS)
                next_s.rdata = {11'h000, s.phase == PSC_SETTLE, s.pump_on};
            else if ((reg_req.addr & `PSC_RT_MASK) == `PSC_OFS_RT0)
                next_s.rdata = hrs[reg_req.addr[1:0]]; // RL9
        end

        // Staging sequencer
        case (s.phase)
            PSC_READY:
            begin
                if (enabled)
                begin
                    if (want_on && have_off)
                    begin
                        next_s.pump_on[min_idx] = 1'b1; // RL4
                        next_s.phase = PSC_SETTLE;
                    end
                    else if (want_off && have_on)
                    begin
                        next_s.pump_on[max_idx] = 1'b0; // RL6
                        next_s.phase = PSC_SETTLE;
                    end
                    else if (imbalance)
                    begin
                        // Swap counts as one transition
                        next_s.pump_on[min_idx] = 1'b1; // RL3
                        next_s.pump_on[max_idx] = 1'b0; // RL3
                        next_s.phase = PSC_SETTLE;
                    end
                end
                if (next_s.phase == PSC_SETTLE)
                begin
                    // Restart timebase so the delay is exact
                    next_s.settle = s.cfg.settle_s; // RL8
                    next_s.presc = 32'h0000_0000;
                    next_s.tick = 1'b0;
                end
            end
            PSC_SETTLE:
            begin
                if (s.tick)
                begin
                    next_s.settle = s.settle - 16'h0001;
                    if (s.settle <= 16'h0001)
                        next_s.phase = PSC_READY; // RL8
                end
            end
            default:
                next_s.phase = PSC_READY;
        endcase

        // Disabled or out-of-range slots are forced off at once
        next_s.pump_on = next_s.pump_on & avail; // RL1
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s <= '0;
            s.cfg.func <= `PSC_RST_FUNC;
            s.cfg.count <= `PSC_RST_COUNT;
            s.cfg.chg <= `PSC_RST_CHG;
            s.cfg.start <= `PSC_RST_START;
            s.cfg.stop <= `PSC_RST_STOP;
            s.cfg.settle_s <= `PSC_RST_SETTLE;
            s.cfg.clr <= `PSC_RST_CLR;
        end
        else
            s <= next_s;
    end

    assign reg_rdata = s.rdata;
    assign pump_on = s.pump_on;

    // Checks on the sequencer, the registers and the run clocks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_ready;
        s.phase == PSC_READY && enabled;
    endsequence

    sequence s_start;
        s_ready ##0 want_on && have_off;
    endsequence

    sequence s_stop;
        s_ready ##0 !(want_on && have_off) && want_off && have_on;
    endsequence

    sequence s_settling;
        s.phase == PSC_SETTLE && enabled && (s.pump_on & ~avail) == 4'h0;
    endsequence

    disabled_all_off_a: assert property ( // RL1
        !enabled |=> pump_on == 4'h0)
        else $error("pump running while staging disabled");

    count_limit_a: assert property ( // RL2
        (pump_on & ~$past(avail)) == 4'h0
        && s.cfg.count >= `PSC_COUNT_MIN && s.cfg.count <= `PSC_COUNT_MAX)
        else $error("pump beyond configured count");

    start_lowest_a: assert property ( // RL5
        s_start |=> pump_on[$past(min_idx)] && !$past(pump_on[min_idx])
        && s.phase == PSC_SETTLE)
        else $error("switch-on missed or not lowest run time");

    lowest_pick_a: assert property ( // RL5
        have_off |-> avail[min_idx] && !s.pump_on[min_idx] && (&min_ok))
        else $error("switch-on candidate not lowest run time");

    highest_pick_a: assert property ( // RL7
        have_on |-> s.pump_on[max_idx] && (&max_ok))
        else $error("switch-off candidate not highest run time");

    start_cause_a: assert property ( // RL4
        s.phase == PSC_READY && !want_on && !imbalance
        |=> (pump_on & ~$past(pump_on)) == 4'h0)
        else $error("pump switched on without cause");

    stop_highest_a: assert property ( // RL7
        s_stop |=> !pump_on[$past(max_idx)] && s.phase == PSC_SETTLE)
        else $error("switch-off missed or not highest run time");

    swap_duty_a: assert property ( // RL3
        s_ready ##0 !(want_on && have_off) && !(want_off && have_on)
        && imbalance |=> pump_on[$past(min_idx)]
        && !pump_on[$past(max_idx)])
        else $error("duty changeover did not rotate pumps");

    settle_hold_a: assert property ( // RL8
        s_settling |=> $stable(pump_on))
        else $error("transition during settle time");

    settle_range_a: assert property ( // RL8
        s.cfg.settle_s >= `PSC_SETTLE_MIN
        && s.cfg.settle_s <= `PSC_SETTLE_MAX)
        else $error("settle time out of range");

    hysteresis_band_a: assert property ( // RL11
        s.cfg.start >= s.cfg.stop)
        else $error("start threshold below stop threshold");

    clock_clear_a: assert property ( // RL10
        s.cfg.clr |=> hrs[0] == 16'h0000 && hrs[1] == 16'h0000
        && hrs[2] == 16'h0000 && hrs[3] == 16'h0000)
        else $error("run-time clocks not cleared");

    runtime_read_a: assert property ( // RL9
        reg_req.rd && reg_req.addr == `PSC_OFS_RT0
        |=> reg_rdata == $past(hrs[0]))
        else $error("run-time view read wrong");

endmodule // psc_staging
`default_nettype wire

// ### testbench/psc_pump_bank.sv
// Purpose: Model of the assist pump starters beside the staging block.
// Assumes: Each direct line starter follows its run command one edge late.
// Notes: Counts pump starts so the bench can catch chatter or lost starts.
`timescale 1ns/1ns
`default_nettype none

module psc_pump_bank
(
    input wire logic sys_clk, // System clock
    input wire logic reset_n, // Async reset, active low
    input wire logic [3:0] pump_on, // Run commands from the block
    output logic [3:0] running, // Contactor state of each pump
    output logic [7:0] starts // Starts counted over all pumps
);
    // Contactor closes one edge after its command; no soft start ramp
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            running <= 4'h0;
            starts <= 8'h00;
        end
        else
        begin
            running <= pump_on;
            starts <= starts + 8'($countones(pump_on & ~running));
        end
    end
endmodule // psc_pump_bank

`default_nettype wire

// ### testbench/psc_staging_bench.sv
// Purpose: Self-checking bench of the pump staging controller.
// Assumes: Short tick and hour so settle and run clocks pass quickly.
// Notes: Reads are checked from a queue one cycle after the strobe.
`timescale 1ns/1ns
`default_nettype none

module psc_staging_bench
    import psc_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    psc_req_type reg_req = '0;
    logic [15:0] drive_speed = 16'h0000;
    logic [15:0] reg_rdata;
    logic [3:0] pump_on;
    logic [3:0] running;
    logic [7:0] starts;
    logic [15:0] expq[$];
    logic rd_seen = 1'b0;
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed = 33322;

    // 50 MHz system clock
    always #10 sys_clk = ~sys_clk;

    // Ten cycles a second, four seconds an hour: settle of 2 s is 20 cycles
    psc_staging #(.TICK_CYCLES(10), .SEC_PER_HOUR(4)) psc_staging_i
    (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .reg_req(reg_req),
        .drive_speed(drive_speed),
        .reg_rdata(reg_rdata),
        .pump_on(pump_on)
    );

    psc_pump_bank psc_pump_bank_i
    (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pump_on(pump_on),
        .running(running),
        .starts(starts)
    );

    task automatic summarize();
        $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge sys_clk)
    begin
        if (rd_seen)
            check(reg_rdata, expq.pop_front());
        rd_seen <= reg_req.rd;
    end

    // Hang guard; the whole sequence needs well under a thousand cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            error_cnt++;
            summarize();
        end
    end

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_req.addr <= a;
        reg_req.wdata <= d;
        reg_req.wr <= 1'b1;
        @(posedge sys_clk);
        reg_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        reg_req.addr <= a;
        reg_req.rd <= 1'b1;
        expq.push_back(e);
        @(posedge sys_clk);
        reg_req.rd <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic speed(input logic [15:0] v);
        @(posedge sys_clk);
        drive_speed <= v;
    endtask

    // Random speed inside the hysteresis band, where only a duty swap may change the pumps
    function automatic logic [15:0] band();
        band = 16'(301 + ({$random(seed)} % 189));
    endfunction

    task automatic pumps(input logic [3:0] e);
        @(posedge sys_clk);
        #1;
        check({12'h000, pump_on}, {12'h000, e});
    endtask

    // Bounded wait for the next change of the run outputs
    task automatic await(input int lim, input logic [3:0] e);
        logic [3:0] old;
        old = pump_on;
        repeat (lim)
        begin
            @(posedge sys_clk);
            #1;
            if (pump_on !== old)
                break;
        end
        check({12'h000, pump_on}, {12'h000, e});
    endtask

    initial
    begin
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        // Reset values, status and an unmapped index
        rd(4'h0, 16'h0000);
        rd(4'h1, 16'h0001);
        rd(4'h2, 16'h0000);
        rd(4'h3, 16'h01EA);
        rd(4'h4, 16'h012C);
        rd(4'h5, 16'h003C);
        rd(4'h6, 16'h0000);
        rd(4'h7, 16'h0000);
        rd(4'hC, 16'h0000);
        // Out of range writes are clamped, thresholds keep their order
        wr(4'h1, 16'h0007);
        rd(4'h1, 16'h0004);
        wr(4'h5, 16'h0001);
        rd(4'h5, 16'h0002);
        wr(4'h0, 16'h0007);
        rd(4'h0, 16'h0005);
        wr(4'h3, 16'h0064);
        rd(4'h3, 16'h012C);
        wr(4'h4, 16'h0200);
        rd(4'h4, 16'h012C);
        wr(4'h3, 16'h01EA);
        wr(4'h1, 16'h0001);
        wr(4'h0, 16'h0000);
        // High speed while disabled must not start anything
        speed(16'(491 + ({$random(seed)} % 500)));
        idle(30);
        pumps(4'h0);
        wr(4'h0, 16'h0001);
        await(10, 4'h1);
        // Only one pump allowed, so the second stays off for long
        idle(120);
        pumps(4'h1);
        wr(4'h1, 16'h0002);
        await(10, 4'h3);
        rd(4'h7, 16'h0013);
        speed(band());
        idle(40);
        pumps(4'h3);
        // Pump 0 has run longest, so it goes off first
        speed(16'h0064);
        await(30, 4'h2);
        idle(12);
        pumps(4'h2);
        await(30, 4'h0);
        // Pump 1 has fewer hours than pump 0, so it is chosen
        speed(16'h0258);
        await(30, 4'h2);
        // Clear holds every run clock at zero
        speed(band());
        wr(4'h6, 16'h0001);
        idle(3);
        rd(4'h8, 16'h0000);
        rd(4'h9, 16'h0000);
        rd(4'hA, 16'h0000);
        rd(4'hB, 16'h0000);
        rd(4'h6, 16'h0001);
        wr(4'h6, 16'h0000);
        // One hour of spread swaps the running pump for the idle one
        wr(4'h2, 16'h0001);
        speed(band());
        await(200, 4'h1);
        // Idle pump now leads, so no swap back after settling
        idle(30);
        pumps(4'h1);
        // Disable forces the running pump off, here after settling has ended
        wr(4'h0, 16'h0000);
        idle(2);
        pumps(4'h0);
        idle(2);
        check({8'h00, starts}, 16'h0004);
        summarize();
    end
endmodule // psc_staging_bench

`default_nettype wire
